// ---- rtl/qd_axis.sv ----
`timescale 1ns/1ns
`default_nettype none
module qd_axis (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Sampling tick and channel setup
	input wire logic tick,
	input wire logic enable,
	input wire logic edge_mode,
	// Filtered encoder phases
	input wire logic phase_a,
	input wire logic phase_b,
	// Results
	output logic [qd_pkg::QD_CNT_W-1:0] count,
	output logic step
);
	import qd_pkg::*;

	typedef struct packed {
		logic pa;
		logic pb;
		logic [QD_CNT_W-1:0] cnt;
		logic ev;
	} qd_axis_t;

	qd_axis_t st;
	qd_axis_t next_st;

	//--------------------------------------------------------------
	// Step decode
	//--------------------------------------------------------------
	// Phases are compared only on ticks, so the tick rate bounds speed
	always_comb begin
		next_st = st;
		next_st.ev = 1'h0;
		if (!enable) begin
			next_st.cnt = 16'h0000;
			next_st.pa = phase_a;
			next_st.pb = phase_b;
		end else if (tick) begin
			next_st.pa = phase_a;
			next_st.pb = phase_b;
			if (edge_mode) begin
				// Both phases moving together still adds just one
				if ((phase_a ^ st.pa) | (phase_b ^ st.pb)) begin
					next_st.cnt = st.cnt + 16'h0001;
					next_st.ev = 1'h1;
				end
			end else if ((phase_a ^ st.pa) ^ (phase_b ^ st.pb)) begin
				// Double change is a lost step and is not counted
				if (phase_a ^ st.pb) begin
					next_st.cnt = st.cnt + 16'h0001;
				end else begin
					next_st.cnt = st.cnt - 16'h0001;
				end
				next_st.ev = 1'h1;
			end
		end
	end

	// State register; signed two's-complement count wraps
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '{pa: 1'h0, pb: 1'h0, cnt: 16'h0000, ev: 1'h0};
		end else begin
			st <= next_st;
		end
	end

	assign count = st.cnt;
	assign step = st.ev;
endmodule
`default_nettype wire

// ---- rtl/qd_pkg.sv ----
//----------------------------------------------------------------------
// Shared constants and state layout of the three-axis decoder
//----------------------------------------------------------------------
package qd_pkg;

	//------------------------------------------------------------------
	// Register map: printed offsets, bus byte address is four times the offset from QD_BASE
	//------------------------------------------------------------------
	localparam logic [31:0] QD_BASE = 32'h50000200;
	localparam logic [31:0] QD_OFS_CTRL = 32'h50000200;
	localparam logic [31:0] QD_OFS_X = 32'h50000202;
	localparam logic [31:0] QD_OFS_Y = 32'h50000204;
	localparam logic [31:0] QD_OFS_DIV = 32'h50000206;
	localparam logic [31:0] QD_OFS_CFG = 32'h50000208;
	localparam logic [31:0] QD_OFS_Z = 32'h5000020A;
	localparam logic [31:0] QD_OFS_TOT = 32'h5000020C;
	localparam int QD_ADR_W = 8;
	localparam logic [7:0] QD_BA_CTRL = 8'((QD_OFS_CTRL - QD_BASE) << 2);
	localparam logic [7:0] QD_BA_X = 8'((QD_OFS_X - QD_BASE) << 2);
	localparam logic [7:0] QD_BA_Y = 8'((QD_OFS_Y - QD_BASE) << 2);
	localparam logic [7:0] QD_BA_DIV = 8'((QD_OFS_DIV - QD_BASE) << 2);
	localparam logic [7:0] QD_BA_CFG = 8'((QD_OFS_CFG - QD_BASE) << 2);
	localparam logic [7:0] QD_BA_Z = 8'((QD_OFS_Z - QD_BASE) << 2);
	localparam logic [7:0] QD_BA_TOT = 8'((QD_OFS_TOT - QD_BASE) << 2);

	//------------------------------------------------------------------
	// Field positions and widths
	//------------------------------------------------------------------
	localparam int QD_THRES_LSB = 3;
	localparam int QD_THRES_MSB = 10;
	localparam int QD_PEND_BIT = 2;
	localparam int QD_EVCLR_BIT = 1;
	localparam int QD_UNMASK_BIT = 0;
	localparam int QD_PRE_BIT = 10;
	localparam int QD_DIV_W = 10;
	localparam int QD_MODE_LSB = 9;
	localparam int QD_SEL_W = 3;
	localparam int QD_CNT_W = 16;
	localparam int QD_PINS = 12;

	//------------------------------------------------------------------
	// Values after reset
	//------------------------------------------------------------------
	localparam logic [7:0] QD_THRES_RST = 8'h02;
	localparam logic QD_UNMASK_RST = 1'h1;
	localparam logic [9:0] QD_DIV_RST = 10'h3E7;
	localparam logic QD_PRE_RST = 1'h0;
	localparam logic [2:0] QD_MODE_RST = 3'h7;
	localparam logic [2:0] QD_SELX_RST = 3'h1;
	localparam logic [2:0] QD_SELY_RST = 3'h2;
	localparam logic [2:0] QD_SELZ_RST = 3'h3;

	//------------------------------------------------------------------
	// Top-level state
	//------------------------------------------------------------------
	typedef struct packed {
		logic [11:0] s1;
		logic [11:0] s2;
		logic [11:0] s3;
		logic [11:0] filt;
		logic [9:0] div_cnt;
		logic pre;
		logic tick;
		logic [7:0] thres;
		logic pending;
		logic unmask;
		logic [2:0] mode;
		logic [8:0] sel;
		logic [9:0] div_val;
		logic pre_en;
		logic [7:0] total;
		logic [8:0] acc;
		logic ack;
		logic [15:0] dat;
		logic irq;
	} qd_state_t;

	localparam qd_state_t QD_STATE_RST = '{
		s1: 12'h000, s2: 12'h000, s3: 12'h000, filt: 12'h000,
		div_cnt: QD_DIV_RST, pre: 1'h0, tick: 1'h0,
		thres: QD_THRES_RST, pending: 1'h0, unmask: QD_UNMASK_RST,
		mode: QD_MODE_RST, sel: {QD_SELZ_RST, QD_SELY_RST, QD_SELX_RST},
		div_val: QD_DIV_RST, pre_en: QD_PRE_RST, total: 8'h00,
		acc: 9'h000, ack: 1'h0, dat: 16'h0000, irq: 1'h0
	};

endpackage

// ---- rtl/qd_top.sv ----
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module qd_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Wishbone classic slave
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [qd_pkg::QD_ADR_W-1:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	// Encoder pins and clock mode
	input wire logic [qd_pkg::QD_PINS-1:0] gpio_in,
	input wire logic low_power_clock,
	// Interrupt
	output logic irq
);
	import qd_pkg::*;

	qd_state_t st;
	qd_state_t next_st;

	logic [2:0] axis_en;
	logic [2:0] axis_a;
	logic [2:0] axis_b;
	logic [2:0] axis_step;
	logic [QD_CNT_W-1:0] axis_cnt [3];
	logic [1:0] n_ev;
	logic bus_req;
	logic [15:0] lane_m;
	logic wr_ctrl;
	logic clr_pend;
	logic clr_total;
	logic set_irq;

	//------------------------------------------------------------------
	// Pin mapping
	//------------------------------------------------------------------
	// Returns {enable, a, b}; codes 0 and 7 leave the channel disabled
	function automatic logic [2:0] pin_pick(input logic [2:0] s,
			input logic [11:0] p);
		case (s)
			3'h1: pin_pick = {1'h1, p[2], p[5]};
			3'h2: pin_pick = {1'h1, p[1], p[4]};
			3'h3: pin_pick = {1'h1, p[3], p[10]};
			3'h4: pin_pick = {1'h1, p[6], p[7]};
			3'h5: pin_pick = {1'h1, p[8], p[9]};
			3'h6: pin_pick = {1'h1, p[0], p[11]};
			default: pin_pick = 3'h0;
		endcase
	endfunction

	//------------------------------------------------------------------
	// Axis decoders
	//------------------------------------------------------------------
	for (genvar i = 0; i < 3; i++) begin : g_axis
		assign {axis_en[i], axis_a[i], axis_b[i]} =
			pin_pick(st.sel[QD_SEL_W*i +: QD_SEL_W], st.filt);
		qd_axis u_axis (
			.clk(clk),
			.rst(rst),
			.tick(st.tick),
			.enable(axis_en[i]),
			.edge_mode(st.mode[i]),
			.phase_a(axis_a[i]),
			.phase_b(axis_b[i]),
			.count(axis_cnt[i]),
			.step(axis_step[i])
		);
	end

	// Events seen this cycle over all three channels
	assign n_ev = {1'h0, axis_step[0]} + {1'h0, axis_step[1]}
		+ {1'h0, axis_step[2]};

	//------------------------------------------------------------------
	// Bus decode helpers
	//------------------------------------------------------------------
	// Ack is held one cycle only, so a request is taken once
	assign bus_req = wb_cyc && wb_stb && !st.ack;
	assign lane_m = {{8{wb_sel[1]}}, {8{wb_sel[0]}}};
	assign wr_ctrl = bus_req && wb_we && (wb_adr == QD_BA_CTRL);
	assign clr_pend = wr_ctrl && lane_m[QD_PEND_BIT]
		&& wb_dat_w[QD_PEND_BIT];
	assign clr_total = wr_ctrl && lane_m[QD_EVCLR_BIT]
		&& wb_dat_w[QD_EVCLR_BIT];

	//------------------------------------------------------------------
	// Next-state logic
	//------------------------------------------------------------------
	always_comb begin
		logic [15:0] cur;
		logic [15:0] merged;
		logic [15:0] rd;
		logic [11:0] diff;
		logic [8:0] acc_sum;
		logic base_tick;
		cur = 16'h0000;
		merged = 16'h0000;
		rd = 16'h0000;
		diff = st.s2 ^ st.s3;
		acc_sum = st.acc + {7'h00, n_ev};
		base_tick = 1'h0;
		set_irq = 1'h0;
		next_st = st;

		// Pin filter: a level is taken once two late stages agree
		next_st.s1 = gpio_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.filt = (st.s3 & ~diff) | (st.filt & diff);

		// Tick divider; the prescaler halves whatever rate results
		if (low_power_clock) begin
			base_tick = 1'h1;
			next_st.div_cnt = st.div_val;
		end else if (st.div_cnt == 10'h000) begin
			base_tick = 1'h1;
			next_st.div_cnt = st.div_val;
		end else begin
			next_st.div_cnt = st.div_cnt - 10'h001;
		end
		next_st.tick = 1'h0;
		if (base_tick) begin
			if (st.pre_en) begin
				next_st.pre = ~st.pre;
				next_st.tick = st.pre;
			end else begin
				next_st.tick = 1'h1;
			end
		end

		// Event total; fresh events win over a clear
		if (clr_total) begin
			next_st.total = {6'h00, n_ev};
		end else begin
			next_st.total = st.total + {6'h00, n_ev};
		end

		// Threshold accumulator restarts after each interrupt
		if (acc_sum > {1'h0, st.thres}) begin
			set_irq = 1'h1;
			next_st.acc = 9'h000;
		end else begin
			next_st.acc = acc_sum;
		end

		// Bus handshake: answer one cycle after the request
		next_st.ack = bus_req;

		// Register writes merge only the enabled byte lanes
		if (bus_req && wb_we) begin
			case (wb_adr)
				QD_BA_CTRL: begin
					cur = {5'h00, st.thres, 3'h0};
					merged = (cur & ~lane_m) | (wb_dat_w[15:0] & lane_m);
					next_st.thres = merged[QD_THRES_MSB:QD_THRES_LSB];
					if (lane_m[QD_UNMASK_BIT]) begin
						next_st.unmask = wb_dat_w[QD_UNMASK_BIT];
					end
				end
				QD_BA_DIV: begin
					cur = {5'h00, st.pre_en, st.div_val};
					merged = (cur & ~lane_m) | (wb_dat_w[15:0] & lane_m);
					next_st.div_val = merged[QD_DIV_W-1:0];
					next_st.pre_en = merged[QD_PRE_BIT];
				end
				QD_BA_CFG: begin
					cur = {4'h0, st.mode, st.sel};
					merged = (cur & ~lane_m) | (wb_dat_w[15:0] & lane_m);
					next_st.sel = merged[8:0];
					next_st.mode = merged[11:QD_MODE_LSB];
				end
				default: begin
					// Counters and unmapped words ignore writes
					merged = 16'h0000;
				end
			endcase
		end

		// Pending flag: a new interrupt wins over a clear
		if (clr_pend) begin
			next_st.pending = 1'h0;
		end
		if (set_irq) begin
			next_st.pending = 1'h1;
		end

		// Read data captured with the answer; unmapped reads zero
		case (wb_adr)
			QD_BA_CTRL: rd = {5'h00, st.thres, st.pending, 1'h0,
				st.unmask};
			QD_BA_X: rd = axis_cnt[0];
			QD_BA_Y: rd = axis_cnt[1];
			QD_BA_DIV: rd = {5'h00, st.pre_en, st.div_val};
			QD_BA_CFG: rd = {4'h0, st.mode, st.sel};
			QD_BA_Z: rd = axis_cnt[2];
			QD_BA_TOT: rd = {8'h00, st.total};
			default: rd = 16'h0000;
		endcase
		if (bus_req && !wb_we) begin
			next_st.dat = rd;
		end

		// Interrupt level follows the registered flag and mask
		next_st.irq = next_st.pending && next_st.unmask;
	end

	//------------------------------------------------------------------
	// State register
	//------------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= QD_STATE_RST;
		end else begin
			st <= next_st;
		end
	end

	assign wb_ack = st.ack;
	assign wb_dat_r = {16'h0000, st.dat};
	assign irq = st.irq;

	//------------------------------------------------------------------
	// Checks
	//------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_rd(logic [7:0] a);
		wb_cyc && wb_stb && !wb_ack && !wb_we && (wb_adr == a);
	endsequence

	sequence s_answer;
		wb_ack ##1 !wb_ack;
	endsequence

	// Exceeding the threshold sets the flag on the next edge
	property p_thres;
		({1'h0, st.acc} + {8'h00, n_ev}) > {2'h0, st.thres}
			|=> st.pending;
	endproperty
	a_thres: assert property (p_thres)
		else $error("threshold reached but no pending interrupt");

	// Pending flag stays until cleared
	property p_hold;
		st.pending && !clr_pend |=> st.pending;
	endproperty
	a_hold: assert property (p_hold)
		else $error("pending flag dropped without a clear");

	// Control read shows the flag and a zero clear bit
	property p_rd_ctrl;
		s_rd(QD_BA_CTRL) |=> wb_ack && (wb_dat_r[QD_PEND_BIT]
			== $past(st.pending)) && !wb_dat_r[QD_EVCLR_BIT];
	endproperty
	a_rd_ctrl: assert property (p_rd_ctrl)
		else $error("control read shows wrong flag bits");

	// Writing one clears the flag unless a new interrupt arrives
	property p_w1c;
		clr_pend && !set_irq |=> !st.pending && !irq;
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("pending flag not cleared by write of one");

	// Clearing the total in a cycle with no events leaves zero
	property p_evclr;
		clr_total && (n_ev == 2'h0) |=> (st.total == 8'h00);
	endproperty
	a_evclr: assert property (p_evclr)
		else $error("event total not cleared");

	// Masked interrupt never reaches the pin
	property p_mask;
		!st.unmask && !wr_ctrl |=> !irq;
	endproperty
	a_mask: assert property (p_mask)
		else $error("interrupt output high while masked");

	// Disabled channel reads zero
	property p_zero;
		!axis_en[0] |=> (axis_cnt[0] == 16'h0000);
	endproperty
	a_zero: assert property (p_zero)
		else $error("disabled X channel count is not zero");

	// X read returns the count held at the request edge
	property p_rd_x;
		s_rd(QD_BA_X) |=> (wb_dat_r == {16'h0000, $past(axis_cnt[0])})
			and s_answer;
	endproperty
	a_rd_x: assert property (p_rd_x)
		else $error("X counter read mismatch");

	// Divider read returns the stored setting
	property p_rd_div;
		s_rd(QD_BA_DIV) |=> wb_ack
			&& (wb_dat_r[10:0] == $past({st.pre_en, st.div_val}));
	endproperty
	a_rd_div: assert property (p_rd_div)
		else $error("divider read mismatch");

	// Event total read at its own address
	property p_rd_tot;
		s_rd(QD_BA_TOT) |=> wb_ack
			&& (wb_dat_r == {24'h000000, $past(st.total)});
	endproperty
	a_rd_tot: assert property (p_rd_tot)
		else $error("event total read mismatch");

	// Total advances by exactly the events seen
	property p_total;
		!clr_total |=> st.total == 8'($past(st.total) + {6'h00, $past(n_ev)});
	endproperty
	a_total: assert property (p_total)
		else $error("event total did not follow events");

	// With a non-zero divider and no low-power bypass, ticks never come back to back
	property p_tick;
		st.tick && !low_power_clock && (st.div_val != 10'h000)
			&& $stable(st.div_val) |=> !st.tick;
	endproperty
	a_tick: assert property (p_tick)
		else $error("ticks too close for divider setting");

	// With the prescaler on, ticks never come back to back
	property p_pre;
		st.tick && st.pre_en && $stable(st.pre_en) |=> !st.tick;
	endproperty
	a_pre: assert property (p_pre)
		else $error("prescaled ticks too close");
endmodule
`default_nettype wire

// ---- verification/qd_enc_model.sv ----
`timescale 1ns/1ns
`default_nettype none
//----------------------------------------------------------------------
// Encoder model driving the decoder pins
//----------------------------------------------------------------------
module qd_enc_model (
	// Clock
	input wire logic clk,
	// Phase outputs toward the pins
	output logic [11:0] pins
);
	// Every encoder parks at phase 00 at power-up
	initial begin
		pins = 12'h000;
	end

	// Hold phases long enough for the filter and a fast tick
	task automatic settle();
		repeat (12) @(posedge clk);
	endtask

	// One Gray step; with fwd set phase A leads phase B
	task automatic quad(input int a, input int b, input bit fwd);
		logic pa;
		logic pb;
		pa = pins[a];
		pb = pins[b];
		@(posedge clk);
		pins[a] <= fwd ? ~pb : pb;
		pins[b] <= fwd ? pa : ~pa;
		settle();
	endtask

	// Toggle pins together; a two-pin mask is a simultaneous change
	task automatic flip(input logic [11:0] m);
		@(posedge clk);
		pins <= pins ^ m;
		settle();
	endtask
endmodule
`default_nettype wire

// ---- verification/three_axis_quadrature_decoder_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module three_axis_quadrature_decoder_tb_top;
	import qd_pkg::*;
	//------------------------------------------------------------------
	// Signals
	//------------------------------------------------------------------
	typedef struct {
		logic [7:0] adr;
		logic [15:0] val;
	} qd_row_t;
	logic clk;
	logic rst;
	logic wb_cyc;
	logic wb_stb;
	logic wb_we;
	logic [QD_ADR_W-1:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat_w;
	logic [31:0] wb_dat_r;
	logic wb_ack;
	logic [QD_PINS-1:0] gpio_in;
	logic low_power_clock;
	logic irq;
	logic [15:0] rd;
	int errors;
	int compares;
	qd_row_t rows [8];

	qd_top u_dut (
		.clk(clk),
		.rst(rst),
		.wb_cyc(wb_cyc),
		.wb_stb(wb_stb),
		.wb_we(wb_we),
		.wb_adr(wb_adr),
		.wb_sel(wb_sel),
		.wb_dat_w(wb_dat_w),
		.wb_dat_r(wb_dat_r),
		.wb_ack(wb_ack),
		.gpio_in(gpio_in),
		.low_power_clock(low_power_clock),
		.irq(irq)
	);

	qd_enc_model u_enc (
		.clk(clk),
		.pins(gpio_in)
	);

	// 250 MHz system clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------
	task automatic wrap_up();
		if (errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// Classic single cycle; request held until ack is seen at an edge
	task automatic bus(input logic we, input logic [7:0] a,
		input logic [15:0] d, output logic [15:0] q);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hF;
		wb_dat_w <= {16'h0000, d};
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		q = wb_dat_r[15:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		if (wb_ack !== 1'b1) begin
			errors++;
			$display("unexpected at %0t: no bus ack", $time);
			wrap_up();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, a, d, rd);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
		bus(1'b0, a, 16'h0000, rd);
		chk(rd, exp);
	endtask

	// Poll a count until it moves; the divided tick may be far off
	task automatic wait_move(input logic [7:0] a, input logic [15:0] old);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 16'h0000, rd);
			n++;
		end while (rd === old && n < 400);
		if (rd === old) begin
			errors++;
			$display("unexpected at %0t: count never moved", $time);
			wrap_up();
		end
	endtask

	//------------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------------
	initial begin
		rst = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'h0;
		wb_dat_w = 32'h00000000;
		low_power_clock = 1'b0;
		errors = 0;
		compares = 0;
		rows = '{'{QD_BA_CTRL, 16'h0011}, '{QD_BA_X, 16'h0000},
			'{QD_BA_Y, 16'h0000}, '{QD_BA_DIV, 16'h03E7},
			'{QD_BA_CFG, 16'h0ED1}, '{QD_BA_Z, 16'h0000},
			'{QD_BA_TOT, 16'h0000}, '{8'h34, 16'h0000}};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		// Reset values across the whole map, one unmapped hole
		foreach (rows[i]) begin
			bus(1'b0, rows[i].adr, 16'h0000, rd);
			chk(rd, rows[i].val);
		end
		// Fast tick and plain quadrature on all three axes
		wr(QD_BA_DIV, 16'h0000);
		wr(QD_BA_CFG, 16'h00D1);
		// A new divider applies only once the running count is used up
		repeat (int'(QD_DIV_RST) + 2) @(posedge clk);
		u_enc.quad(2, 5, 1'b1);
		u_enc.quad(2, 5, 1'b1);
		chk(16'(irq), 16'h0000);
		u_enc.quad(2, 5, 1'b1);
		chk(16'(irq), 16'h0001);
		rdchk(QD_BA_CTRL, 16'h0015);
		rdchk(QD_BA_X, 16'h0003);
		rdchk(QD_BA_TOT, 16'h0003);
		// Counts ignore bus writes
		wr(QD_BA_X, 16'h1234);
		rdchk(QD_BA_X, 16'h0003);
		// Mask with a zero on the pending bit, then unmask again
		wr(QD_BA_CTRL, 16'h0010);
		rdchk(QD_BA_CTRL, 16'h0014);
		chk(16'(irq), 16'h0000);
		wr(QD_BA_CTRL, 16'h0011);
		rdchk(QD_BA_CTRL, 16'h0015);
		chk(16'(irq), 16'h0001);
		// Write one to clear pending, then clear the event total
		wr(QD_BA_CTRL, 16'h0015);
		rdchk(QD_BA_CTRL, 16'h0011);
		chk(16'(irq), 16'h0000);
		wr(QD_BA_CTRL, 16'h0013);
		rdchk(QD_BA_CTRL, 16'h0011);
		rdchk(QD_BA_TOT, 16'h0000);
		// B leading gives a negative two's-complement count
		u_enc.quad(1, 4, 1'b0);
		rdchk(QD_BA_Y, 16'hFFFF);
		// Z in edge mode: one edge, then both phases at once
		wr(QD_BA_CFG, 16'h08D1);
		u_enc.flip(12'h008);
		u_enc.flip(12'h408);
		rdchk(QD_BA_Z, 16'h0002);
		rdchk(QD_BA_TOT, 16'h0003);
		chk(16'(irq), 16'h0001);
		// Both "none" selections force X to zero
		wr(QD_BA_CFG, 16'h08D0);
		rdchk(QD_BA_X, 16'h0000);
		wr(QD_BA_CFG, 16'h08D7);
		rdchk(QD_BA_X, 16'h0000);
		// Slow divider: a step waits for the tick unless bypassed
		wr(QD_BA_DIV, 16'h03FF);
		rdchk(QD_BA_DIV, 16'h03FF);
		u_enc.quad(1, 4, 1'b1);
		wait_move(QD_BA_Y, 16'hFFFF);
		u_enc.quad(1, 4, 1'b1);
		rdchk(QD_BA_Y, 16'h0000);
		low_power_clock <= 1'b1;
		repeat (12) @(posedge clk);
		rdchk(QD_BA_Y, 16'h0001);
		// Prescaler halves the bypassed rate, steps still land
		wr(QD_BA_DIV, 16'h07FF);
		rdchk(QD_BA_DIV, 16'h07FF);
		u_enc.quad(1, 4, 1'b1);
		rdchk(QD_BA_Y, 16'h0002);
		// Mid-run reset; slow tick keeps the parked pins from counting
		low_power_clock <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk(16'(irq), 16'h0000);
		rdchk(QD_BA_CTRL, 16'h0011);
		rdchk(QD_BA_Y, 16'h0000);
		rdchk(QD_BA_TOT, 16'h0000);
		wrap_up();
	end
endmodule
`default_nettype wire
